//--- mpr_consts.svh
// Constants for the multipurpose register readout block.
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH
`define MR_SEL_MR0          3'h0
`define MR_SEL_MR1          3'h1
`define MR_SEL_MR2          3'h2
`define MR_SEL_MR3          3'h3
`define MR_SEL_MR5          3'h5
`define MR_SEL_MR6          3'h6
`define MR3_MPR_EN_BIT      2
`define MR3_GEARDOWN_BIT    3
`define MR3_PAGE_LSB        0
`define MR3_FMT_LSB         11
`define MR0_BL_LSB          0
`define MR5_RDBI_BIT        12
`define FMT_SERIAL          2'h0
`define FMT_PARALLEL        2'h1
`define FMT_STAGGERED       2'h2
`define PAGE0_LOC0_RESET    8'h55
`define PAGE0_LOC1_RESET    8'h33
`define PAGE0_LOC2_RESET    8'h0f
`define PAGE0_LOC3_RESET    8'h00
`define BC4_UPPER_BIT       2
`define BURST_LEN           4'h8
`define BC4_LEN             4'h4
`define RL_MAX              6'h3f
`define FIFO_DEPTH          8
`endif

//--- mpr_pkg.sv
// Types shared by the multipurpose register readout block.
package mpr_pkg;
  typedef struct packed {
    logic [1:0] loc;
    logic       upper_half;
    logic       chop4;
    logic [7:0] lane0;
    logic [7:0] lane1;
    logic [7:0] lane2;
    logic [7:0] lane3;
  } burst_s;
  typedef struct packed {
    logic [2:0]  sel;
    logic [17:0] addr;
  } mr_write_s;
  typedef struct packed {
    logic [1:0]  ba;
    logic [1:0]  bg;
    logic [17:0] addr;
  } read_cmd_s;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRIVE = 2'b01
  } out_state_e;
endpackage

//--- mpr_fifo.sv
// The read FIFO module is defined in sdram_mpr_readout.sv beside the block that uses it.

//--- sdram_mpr_readout.sv
// Multipurpose register page readout for the DRAM command path.
`timescale 1ns/100ps
`include "mpr_consts.svh"

// Overview of operation
// [R1] Fixed BL8 or BC4 only, no on-the-fly.
// [R2] Ignore read inversion setting in MPR mode.
// [R3] BC4 start column only 000 or 100.
// [R4] Page 0 defaults at reset, writable, retained.
// [R5] Page 0 reads allow short or long spacing.
// [R6] Pages 1-3 reads need long spacing.
// [R7] Lock DLL, precharge all before entry.
// [R8] Mode register 3 enables, formats, selects page.
// [R9] Wait set and update delays before reads.
// [R10] Reads redirected; bank address picks location.
// [R11] BL8 with burst field 01 needs A12 high.
// [R12] A2 selects burst order and half.
// [R13] A1:A0 zero; other address bits ignored.
// [R14] Burst after AL plus CL in format.
// [R15] Wait recovery, then clear enable bit.
// [R16] After update delay, normal commands resume.
// [R17] Page 2 location 0 bits 4:3 temperature.
// [R18] Only limited commands while MPR enabled.
// [R19] Only 1x refresh; no power-down.
// [R20] Pages 1-3 unchanged by MPR writes.
module sdram_mpr_readout (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire mpr_pkg::mr_write_s   mr_wr,
  input  wire logic                 mr_wr_valid,
  input  wire mpr_pkg::read_cmd_s   rd_cmd,
  input  wire logic                 rd_cmd_valid,
  output logic                      rd_cmd_ready,
  input  wire logic [1:0]           mpr_wr_loc,
  input  wire logic [7:0]           mpr_wr_data,
  input  wire logic                 mpr_wr_valid,
  input  wire logic [4:0]           additive_lat,
  input  wire logic [5:0]           cas_lat,
  input  wire logic [1:0]           temp_status,
  input  wire logic [1:0]           crc_par_status,
  input  wire logic [7:0]           err_addr_low,
  input  wire logic [7:0]           err_addr_high,
  input  wire logic [7:0]           err_cmd_bits,
  input  wire logic [2:0]           err_par_latency,
  input  wire logic                 hppr_support,
  input  wire logic                 sppr_support,
  input  wire logic [3:0]           max_activate_count_field,
  output logic                      mpr_mode,
  output logic                      rdbi_effective,
  output logic [15:0]               dq_out,
  output logic                      dq_oe,
  output logic                      burst_active
);
  import mpr_pkg::*;

  logic [17:0] mr0_reg, mr0_next, mr1_reg, mr1_next, mr2_reg, mr2_next;
  logic [17:0] mr3_reg, mr3_next, mr5_reg, mr5_next, mr6_reg, mr6_next;
  logic [7:0]  pat_reg [4];
  logic [7:0]  pat_next [4];
  logic [1:0]  page, fmt;
  logic [6:0]  read_lat;
  logic [7:0]  loc_val [4];

  // Each location returns its byte with bit 7 first in the burst.
  function automatic logic [7:0] lane_byte(input logic [7:0] v);
    lane_byte = v;
  endfunction

  assign mpr_mode = mr3_reg[`MR3_MPR_EN_BIT];
  assign page     = mr3_reg[`MR3_PAGE_LSB +: 2];
  assign fmt      = mr3_reg[`MR3_FMT_LSB +: 2];
  assign read_lat = {2'b00, additive_lat} + {1'b0, cas_lat};
  // Read inversion is forced off while the MPR path owns the bus.
  assign rdbi_effective = mr5_reg[`MR5_RDBI_BIT] && !mpr_mode; // [R2]

  always_comb
  begin
    mr0_next = mr0_reg;
    mr1_next = mr1_reg;
    mr2_next = mr2_reg;
    mr3_next = mr3_reg;
    mr5_next = mr5_reg;
    mr6_next = mr6_reg;
    if (mr_wr_valid)
    begin
      case (mr_wr.sel)
        `MR_SEL_MR0: mr0_next = mr_wr.addr;
        `MR_SEL_MR1: mr1_next = mr_wr.addr;
        `MR_SEL_MR2: mr2_next = mr_wr.addr;
        `MR_SEL_MR3: mr3_next = mr_wr.addr; // [R8] [R15]
        `MR_SEL_MR5: mr5_next = mr_wr.addr;
        `MR_SEL_MR6: mr6_next = mr_wr.addr;
        default:     mr0_next = mr0_reg;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mr0_reg <= '0;
      mr1_reg <= '0;
      mr2_reg <= '0;
      mr3_reg <= '0;
      mr5_reg <= '0;
      mr6_reg <= '0;
    end
    else
    begin
      mr0_reg <= mr0_next;
      mr1_reg <= mr1_next;
      mr2_reg <= mr2_next;
      mr3_reg <= mr3_next;
      mr5_reg <= mr5_next;
      mr6_reg <= mr6_next;
    end
  end

  // Only page 0 is writable; writes aimed at other pages are dropped.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pat_next[i] = pat_reg[i];
    if (mpr_wr_valid && mpr_mode && page == 2'h0) // [R4] [R20]
      pat_next[mpr_wr_loc] = mpr_wr_data;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pat_reg[0] <= `PAGE0_LOC0_RESET; // [R4]
      pat_reg[1] <= `PAGE0_LOC1_RESET;
      pat_reg[2] <= `PAGE0_LOC2_RESET;
      pat_reg[3] <= `PAGE0_LOC3_RESET;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        pat_reg[i] <= pat_next[i];
    end
  end

  // Page contents as seen by a read, built from live state.
  always_comb
  begin
    loc_val[0] = '0;
    loc_val[1] = '0;
    loc_val[2] = '0;
    loc_val[3] = '0;
    case (page)
      2'h0:
      begin
        for (int i = 0; i < 4; i++)
          loc_val[i] = pat_reg[i];
      end
      2'h1:
      begin
        loc_val[0] = err_addr_low;
        loc_val[1] = err_addr_high;
        loc_val[2] = err_cmd_bits;
        loc_val[3] = {crc_par_status, 1'b0, err_par_latency[2], 1'b0, err_par_latency[1:0], 1'b0};
      end
      2'h2:
      begin
        loc_val[0] = {hppr_support, sppr_support, mr2_reg[11], temp_status, // [R17]
                      mr2_reg[12], mr2_reg[10:9]};
        loc_val[1] = {mr6_reg[6], mr6_reg[5:0], mr3_reg[`MR3_GEARDOWN_BIT]};
        loc_val[2] = {mr0_reg[6:4], mr0_reg[2], mr0_reg[12], mr2_reg[5:3]};
        loc_val[3] = {mr1_reg[10:8], mr5_reg[8:6], mr1_reg[2:1]};
      end
      default:
      begin
        loc_val[3] = {4'h0, max_activate_count_field};
      end
    endcase
  end

  // Read capture: each read accepted while MPR mode is on becomes a burst descriptor.
  burst_s      cap;
  logic        fifo_in_ready, fifo_out_valid, fifo_out_ready;
  burst_s      fifo_out;
  logic [6:0]  lat_cnt_reg, lat_cnt_next;
  logic [3:0]  ui_reg, ui_next;
  out_state_e  st_reg, st_next;
  logic [15:0] dq_next;
  logic        oe_next;
  logic [1:0]  loc_sel;
  logic [2:0]  bit_ui;
  logic [7:0]  src;

  always_comb
  begin
    // Bank address alone picks the location; bank group, A10 and the rest are ignored.
    loc_sel        = rd_cmd.ba; // [R10] [R13]
    cap.loc        = loc_sel;
    // Burst-chop is fixed from mode register 0, never taken from A12. [R1] [R11]
    cap.chop4      = (mr0_reg[`MR0_BL_LSB +: 2] == 2'h2);
    cap.upper_half = cap.chop4 && rd_cmd.addr[`BC4_UPPER_BIT]; // [R12]
    cap.lane0      = lane_byte(loc_val[loc_sel]);
    cap.lane1      = lane_byte(loc_val[2'(loc_sel + 2'h1)]);
    cap.lane2      = lane_byte(loc_val[2'(loc_sel + 2'h2)]);
    cap.lane3      = lane_byte(loc_val[2'(loc_sel + 2'h3)]);
  end

  assign rd_cmd_ready = fifo_in_ready;

  mpr_fifo #(
    .WIDTH ($bits(burst_s)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (cap),
    .in_valid  (rd_cmd_valid && mpr_mode), // [R10]
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  // Output sequencer: wait read latency, then drive one UI per cycle.
  assign fifo_out_ready = (st_reg == ST_DRIVE) &&
                          (ui_reg == (fifo_out.chop4 ? `BC4_LEN : `BURST_LEN) - 4'h1);

  always_comb
  begin
    st_next      = st_reg;
    lat_cnt_next = lat_cnt_reg;
    ui_next      = ui_reg;
    dq_next      = '0;
    oe_next      = 1'b0;
    bit_ui       = '0;
    src          = '0;
    case (st_reg)
      ST_IDLE:
      begin
        if (fifo_out_valid)
        begin
          if (lat_cnt_reg >= read_lat) // [R14]
          begin
            st_next = ST_DRIVE;
            ui_next = '0;
          end
          else
            lat_cnt_next = 7'(lat_cnt_reg + 7'h1);
        end
      end
      ST_DRIVE:
      begin
        oe_next = 1'b1;
        for (int q = 0; q < 16; q++)
        begin
          // Serial repeats one byte; parallel repeats the selected location's bits; staggered rotates lanes.
          bit_ui = 3'(ui_reg) + (fifo_out.upper_half ? 3'h4 : 3'h0); // [R12]
          src = fifo_out.lane0;
          if (fmt == `FMT_STAGGERED)
          begin
            case (q % 4)
              1:       src = fifo_out.lane1;
              2:       src = fifo_out.lane2;
              3:       src = fifo_out.lane3;
              default: src = fifo_out.lane0;
            endcase
          end
          if (fmt == `FMT_PARALLEL)
            dq_next[q] = src[3'(7 - (q % 8))];
          else
            dq_next[q] = src[3'(7) - bit_ui]; // [R14]
        end
        if (fifo_out_ready)
        begin
          st_next      = ST_IDLE;
          lat_cnt_next = '0;
        end
        else
          ui_next = 4'(ui_reg + 4'h1);
      end
      default:
        st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_reg      <= ST_IDLE;
      lat_cnt_reg <= '0;
      ui_reg      <= '0;
      dq_out      <= '0;
      dq_oe       <= 1'b0;
    end
    else
    begin
      st_reg      <= st_next;
      lat_cnt_reg <= lat_cnt_next;
      ui_reg      <= ui_next;
      dq_out      <= dq_next;
      dq_oe       <= oe_next;
    end
  end

  assign burst_active = (st_reg == ST_DRIVE);
endmodule

// Small synchronous FIFO with valid and ready on both sides.
module mpr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end
endmodule

//--- mpr_readout_properties.sv
// Concurrent checks on the readout block ports.
`timescale 1ns/100ps
module mpr_readout_checker (
  input wire logic               mclk,
  input wire logic               rst,
  input wire mpr_pkg::mr_write_s mr_wr,
  input wire logic               mr_wr_valid,
  input wire logic               mpr_mode,
  input wire logic               rdbi_effective,
  input wire logic [15:0]        dq_out,
  input wire logic               dq_oe,
  input wire logic               burst_active
);
  import mpr_pkg::*;
  logic [3:0] run_reg;
  logic       bc4_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  always_ff @(posedge mclk)
  begin
    run_reg <= (rst || !dq_oe) ? 4'h0 : run_reg + 4'h1;
    if (rst)
      bc4_reg <= 1'b0;
    else if (mr_wr_valid && mr_wr.sel == 3'h0)
      bc4_reg <= (mr_wr.addr[1:0] == 2'h2);
  end
  AST_MODE_SET: assert property (mr_wr_valid && mr_wr.sel == 3'h3 |=> mpr_mode == $past(mr_wr.addr[2]))
    else $error("mpr_mode does not follow enable bit");
  AST_RDBI_SET: assert property (
    mr_wr_valid && mr_wr.sel == 3'h5 |=> rdbi_effective == ($past(mr_wr.addr[12]) && !mpr_mode))
    else $error("rdbi_effective wrong after write");
  AST_RDBI_OFF: assert property (mpr_mode |-> !rdbi_effective)
    else $error("inversion active in mpr mode");
  AST_LEAD: assert property ($rose(burst_active) |=> dq_oe)
    else $error("dq_oe late after burst_active");
  AST_OE_SRC: assert property ($rose(dq_oe) |-> $past(burst_active))
    else $error("dq_oe without burst_active");
  AST_LANES: assert property (dq_oe |-> dq_out[15:8] == dq_out[7:0])
    else $error("upper lanes differ from lower");
  AST_LEN: assert property ($fell(dq_oe) |-> run_reg == (bc4_reg ? 4'h4 : 4'h8))
    else $error("burst length wrong");
  AST_GAP: assert property ($fell(dq_oe) |-> !dq_oe [*8])
    else $error("bursts too close");
  cover property ($rose(dq_oe) && bc4_reg);
  cover property ($rose(dq_oe) && !bc4_reg);
  cover property ($fell(mpr_mode));
endmodule

//--- mpr_ctrl_model.sv
// Controller model issuing mode register writes, MPR writes and reads.
`timescale 1ns/100ps
module mpr_ctrl_model (
  input  wire logic         mclk,
  output mpr_pkg::mr_write_s mr_wr,
  output logic              mr_wr_valid,
  output mpr_pkg::read_cmd_s rd_cmd,
  output logic              rd_cmd_valid,
  input  wire logic         rd_cmd_ready,
  output logic [1:0]        mpr_wr_loc,
  output logic [7:0]        mpr_wr_data,
  output logic              mpr_wr_valid
);
  import mpr_pkg::*;
  // Only these commands exist here, so banks stay idle and no refresh interferes.
  initial
  begin
    mr_wr = '0;
    mr_wr_valid = 1'b0;
    rd_cmd = '0;
    rd_cmd_valid = 1'b0;
    mpr_wr_loc = 2'h0;
    mpr_wr_data = 8'h00;
    mpr_wr_valid = 1'b0;
  end
  task automatic mrs(input logic [2:0] sel, input logic [17:0] a);
    @(posedge mclk);
    mr_wr <= '{sel: sel, addr: a};
    mr_wr_valid <= 1'b1;
    @(posedge mclk);
    mr_wr_valid <= 1'b0;
    mr_wr <= ~mr_wr;
    repeat (24) @(posedge mclk);
  endtask
  task automatic mpw(input logic [1:0] loc, input logic [7:0] d);
    @(posedge mclk);
    mpr_wr_loc <= loc;
    mpr_wr_data <= d;
    mpr_wr_valid <= 1'b1;
    @(posedge mclk);
    mpr_wr_valid <= 1'b0;
  endtask
  task automatic rd(input read_cmd_s c, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    repeat (4) @(posedge mclk);
    rd_cmd <= c;
    rd_cmd_valid <= 1'b1;
    while (!ok && n < 4000)
    begin
      @(negedge mclk);
      ok = rd_cmd_ready;
      n++;
    end
    @(posedge mclk);
    rd_cmd_valid <= 1'b0;
    rd_cmd <= ~c;
  endtask
endmodule

//--- tb.sv
// Self-checking bench for the readout block.
`timescale 1ns/100ps
module tb;
  import mpr_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] seed = 32'h00003ea4;
  logic [4:0] al;
  logic [5:0] cl;
  logic [36:0] st;
  logic [7:0] p0 [4];
  logic [7:0] loc [4];
  logic [1:0] fmt;
  logic ok, oe_d, full_seen;
  int fails, num_checks, bursts, n0, w;
  mr_write_s mr_wr;
  read_cmd_s rd_cmd;
  logic mr_wr_valid, rd_cmd_valid, rd_cmd_ready, mpr_wr_valid;
  logic [1:0] mpr_wr_loc;
  logic [7:0] mpr_wr_data;
  logic mpr_mode, rdbi_effective, dq_oe, burst_active;
  logic [15:0] dq_out;
  always #2 mclk = ~mclk;
  mpr_ctrl_model mpr_ctrl_model_inst (.mclk(mclk), .mr_wr(mr_wr), .mr_wr_valid(mr_wr_valid), .rd_cmd(rd_cmd),
    .rd_cmd_valid(rd_cmd_valid), .rd_cmd_ready(rd_cmd_ready), .mpr_wr_loc(mpr_wr_loc),
    .mpr_wr_data(mpr_wr_data), .mpr_wr_valid(mpr_wr_valid));
  sdram_mpr_readout sdram_mpr_readout_inst (.mclk(mclk), .rst(rst), .mr_wr(mr_wr), .mr_wr_valid(mr_wr_valid),
    .rd_cmd(rd_cmd), .rd_cmd_valid(rd_cmd_valid), .rd_cmd_ready(rd_cmd_ready), .mpr_wr_loc(mpr_wr_loc),
    .mpr_wr_data(mpr_wr_data), .mpr_wr_valid(mpr_wr_valid), .additive_lat(al), .cas_lat(cl),
    .temp_status(st[1:0]), .crc_par_status(st[3:2]), .err_addr_low(st[11:4]), .err_addr_high(st[19:12]),
    .err_cmd_bits(st[27:20]), .err_par_latency(st[30:28]), .hppr_support(st[31]), .sppr_support(st[36]),
    .max_activate_count_field(st[35:32]), .mpr_mode(mpr_mode), .rdbi_effective(rdbi_effective),
    .dq_out(dq_out), .dq_oe(dq_oe), .burst_active(burst_active));
  always @(posedge mclk)
  begin
    oe_d <= dq_oe;
    full_seen <= full_seen | (!rst && !rd_cmd_ready);
    if (dq_oe && !oe_d)
      bursts++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic read_cmd_s mk(input logic [1:0] ba, input logic a2);
    read_cmd_s c;
    c.ba = ba;
    c.bg = 2'(rnd());
    c.addr = 18'(rnd());
    c.addr[2:0] = {a2, 2'h0};
    c.addr[12] = 1'b1;
    return c;
  endfunction
  function automatic logic [15:0] exp_word(input logic [1:0] ba, input int ui);
    logic [15:0] e;
    for (int q = 0; q < 16; q++)
      e[q] = (fmt == 2'h1) ? loc[ba][7 - q % 8] : loc[2'(ba + q)][7 - ui];
    if (fmt == 2'h0)
      e = {16{loc[ba][7 - ui]}};
    return e;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input logic [1:0] ba, input logic a2, input int n);
    int lat;
    mpr_ctrl_model_inst.rd(mk(ba, a2), ok);
    chk("rd accepted", 16'h1, {15'h0, ok});
    lat = 0;
    #1;
    while (dq_oe !== 1'b1 && lat < 300)
    begin
      @(posedge mclk);
      #1;
      lat++;
    end
    chk("latency", 16'(al + cl + 2), 16'(lat));
    if (lat >= 300)
      tally_and_finish();
    for (int i = 0; i < n; i++)
    begin
      chk("dq_out", exp_word(ba, a2 * 4 + i), dq_out);
      @(posedge mclk);
      #1;
    end
    chk("dq_oe end", 16'h0, {15'h0, dq_oe});
  endtask
  initial
  begin
    al = 5'(rnd() % 8);
    cl = 6'(9 + rnd() % 16);
    st = {5'(rnd()), rnd()};
    fails = 0;
    num_checks = 0;
    bursts = 0;
    full_seen = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    p0 = '{8'h55, 8'h33, 8'h0f, 8'h00};
    loc = p0;
    fmt = 2'h0;
    mpr_ctrl_model_inst.mrs(3'h3, 18'h00004);
    for (int b = 0; b < 4; b++)
      rd_chk(2'(b), 1'b0, 8);
    $display("test serial defaults done");
    mpr_ctrl_model_inst.mrs(3'h0, 18'h00002);
    rd_chk(2'h1, 1'b0, 4);
    rd_chk(2'h2, 1'b1, 4);
    mpr_ctrl_model_inst.mrs(3'h0, 18'h00000);
    $display("test chop4 done");
    for (int b = 0; b < 4; b++)
    begin
      p0[b] = 8'(rnd());
      mpr_ctrl_model_inst.mpw(2'(b), p0[b]);
    end
    loc = p0;
    mpr_ctrl_model_inst.mrs(3'h3, 18'h00804);
    fmt = 2'h1;
    rd_chk(2'h0, 1'b0, 8);
    mpr_ctrl_model_inst.mrs(3'h3, 18'h01004);
    fmt = 2'h2;
    rd_chk(2'(rnd()), 1'b0, 8);
    $display("test formats done");
    fmt = 2'h0;
    mpr_ctrl_model_inst.mrs(3'h3, 18'h00005);
    mpr_ctrl_model_inst.mpw(2'h0, ~st[11:4]);
    loc[0] = st[11:4];
    rd_chk(2'h0, 1'b0, 8);
    mpr_ctrl_model_inst.mrs(3'h3, 18'h00006);
    loc[0] = {st[31], st[36], 1'b0, st[1:0], 3'h0};
    rd_chk(2'h0, 1'b0, 8);
    mpr_ctrl_model_inst.mrs(3'h6, 18'h0005a);
    loc[1] = {1'b1, 6'h1a, 1'b0};
    rd_chk(2'h1, 1'b0, 8);
    mpr_ctrl_model_inst.mrs(3'h3, 18'h00007);
    loc[3] = {4'h0, st[35:32]};
    rd_chk(2'h3, 1'b0, 8);
    $display("test read-only pages done");
    mpr_ctrl_model_inst.mrs(3'h3, 18'h00004);
    n0 = bursts;
    for (int i = 0; i < 20; i++)
    begin
      mpr_ctrl_model_inst.rd(mk(2'(rnd()), 1'b0), ok);
      chk("rd accepted", 16'h1, {15'h0, ok});
    end
    w = 0;
    while (bursts < n0 + 20 && w < 4000)
    begin
      @(posedge mclk);
      w++;
    end
    chk("fifo full seen", 16'h1, {15'h0, full_seen});
    chk("burst count", 16'(n0 + 20), 16'(bursts));
    $display("test fifo done");
    mpr_ctrl_model_inst.mrs(3'h5, 18'h01000);
    #1;
    chk("rdbi in mpr", 16'h0, {15'h0, rdbi_effective});
    mpr_ctrl_model_inst.mrs(3'h3, 18'h00000);
    #1;
    chk("rdbi normal", 16'h1, {15'h0, rdbi_effective});
    n0 = bursts;
    mpr_ctrl_model_inst.rd(mk(2'h0, 1'b0), ok);
    repeat (120) @(posedge mclk);
    chk("no burst outside", 16'(n0), 16'(bursts));
    $display("test exit done");
    tally_and_finish();
  end
endmodule
bind sdram_mpr_readout mpr_readout_checker mpr_readout_checker_inst (.mclk(mclk), .rst(rst), .mr_wr(mr_wr),
  .mr_wr_valid(mr_wr_valid), .mpr_mode(mpr_mode), .rdbi_effective(rdbi_effective), .dq_out(dq_out),
  .dq_oe(dq_oe), .burst_active(burst_active));
